// [inc/mph_pkg.sv]
// Constants and types of the parameter command handler.
// Assumes a framed command arrives already decoded into fields.
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package mph_pkg;
    localparam logic [7:0]  MC_VAR      = 8'h01;
    localparam logic [7:0]  SC_READ     = 8'h01;
    localparam logic [7:0]  SC_WRITE    = 8'h02;
    localparam logic [7:0]  MC_OPER     = 8'h30;
    localparam logic [7:0]  SC_INSTR    = 8'h05;
    localparam logic [7:0]  VT_PROTECT  = 8'hC1;
    localparam logic [7:0]  VT_OPER     = 8'hC2;
    localparam logic [7:0]  VT_SETUP    = 8'hC3;
    localparam logic [7:0]  IN_WEN      = 8'h00;
    localparam logic [7:0]  IN_FZERO    = 8'h03;
    localparam logic [7:0]  IN_SRESET   = 8'h06;
    localparam logic [7:0]  IN_AREA1    = 8'h07;
    localparam logic [7:0]  IN_PROT     = 8'h08;
    localparam logic [7:0]  REL_OFF     = 8'h00;
    localparam logic [7:0]  REL_ON      = 8'h01;
    localparam logic [15:0] RC_OK       = 16'h0000;
    localparam logic [15:0] RC_PARAM    = 16'h1100;
    localparam logic [15:0] RC_OPER     = 16'h2203;
    localparam logic [15:0] PROT_LAST   = 16'h0003;
    localparam logic [15:0] OPER_FIRST  = 16'h0001;
    localparam logic [15:0] OPER_LAST   = 16'h0006;
    localparam logic [15:0] SETUP_LAST  = 16'h001D;
    localparam logic [5:0]  PROT_BASE   = 6'h00;
    localparam logic [5:0]  OPER_BASE   = 6'h03;
    localparam logic [5:0]  SETUP_BASE  = 6'h0A;
    localparam int          MEM_DEPTH   = 40;
    localparam logic [5:0]  IDX_LOCK_INIT = 6'h01;
    localparam logic [31:0] LOCK_NO_MOVE  = 32'h0000_0002;
    localparam logic [7:0]  REG_STATUS  = 8'h00;
    localparam logic [7:0]  REG_CTRL    = 8'h04;
    localparam logic [7:0]  REG_LAST_RC = 8'h08;
    localparam int          ST_AREA = 0;
    localparam int          ST_WEN  = 1;
    localparam int          ST_FZ   = 2;
    localparam int          ST_PROT = 3;
    localparam int          ST_FLT  = 4;
    localparam int          CT_HOLD = 0;

    typedef enum logic {AREA_MEASURE = 1'b0, AREA_SUSPEND = 1'b1} mph_area_t;

    typedef struct packed {
        logic [7:0]  main_request_code;
        logic [7:0]  sub_request_code;
        logic [7:0]  var_type;
        logic [15:0] address;
        logic [7:0]  instr_code;
        logic [7:0]  related_info;
        logic [31:0] data;
    } mph_cmd_t;

    typedef struct packed {
        logic [7:0]  main_request_code;
        logic [7:0]  sub_request_code;
        logic [15:0] resp_code;
        logic [31:0] data;
    } mph_rsp_t;
endpackage

// [rtl/mph_command_handler.sv]
// Parameter and instruction command handler of the meter port.
// Assumes commands as one-cycle pulses from the frame decoder and
// fault pins from the measuring front end (asynchronous).
`timescale 1ns/10ps
`default_nettype none
module mph_command_handler (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             cmd_valid,
    input  wire mph_pkg::mph_cmd_t cmd,
    output logic                  rsp_valid,
    output mph_pkg::mph_rsp_t     rsp,
    input  wire logic             no_value_pin,
    input  wire logic             anomaly_pin,
    input  wire logic             range_over_pin,
    output logic                  measuring,
    output logic                  write_enable,
    output logic                  forced_zero,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata
);
    import mph_pkg::*;

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    mph_area_t   area_ff,  nxt_area;
    logic        wen_ff,   nxt_wen;
    logic        fz_ff,    nxt_fz;
    logic        prot_ff,  nxt_prot;
    logic        hold_ff,  nxt_hold;
    logic        rv_ff,    nxt_rv;
    mph_rsp_t    rsp_ff,   nxt_rsp;
    logic [15:0] lrc_ff,   nxt_lrc;
    logic [31:0] rd_ff,    nxt_rd;
    logic [2:0]  flt_s1_ff;
    logic [2:0]  flt_ff;
    logic [31:0] mem_ff [MEM_DEPTH];
    logic        mem_we;
    logic [5:0]  idx;
    logic        idx_ok;
    logic        is_rd, is_wr, is_ins, fault, sreset_go, send;

    // Fault pins pass two flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flt_s1_ff <= 3'h0;
            flt_ff    <= 3'h0;
        end else begin
            flt_s1_ff <= {range_over_pin, anomaly_pin, no_value_pin};
            flt_ff    <= flt_s1_ff;
        end
    end
    assign fault = |flt_ff;

    // -----------------------------------------------------------
    // Address mapping of the three parameter spaces
    // -----------------------------------------------------------
    always_comb begin
        idx    = 6'h00;
        idx_ok = 1'b0;
        unique case (cmd.var_type)
            VT_PROTECT: begin
                idx_ok = cmd.address <= PROT_LAST;
                idx    = PROT_BASE + cmd.address[5:0];
            end
            VT_OPER: begin
                idx_ok = cmd.address >= OPER_FIRST &&
                         cmd.address <= OPER_LAST;
                idx    = OPER_BASE + cmd.address[5:0];
            end
            VT_SETUP: begin
                idx_ok = cmd.address <= SETUP_LAST;
                idx    = SETUP_BASE + cmd.address[5:0];
            end
            default: idx_ok = 1'b0;
        endcase
    end

    assign is_rd  = cmd_valid && cmd.main_request_code == MC_VAR &&
                    cmd.sub_request_code == SC_READ;
    assign is_wr  = cmd_valid && cmd.main_request_code == MC_VAR &&
                    cmd.sub_request_code == SC_WRITE;
    assign is_ins = cmd_valid && cmd.main_request_code == MC_OPER &&
                    cmd.sub_request_code == SC_INSTR;
    assign sreset_go = is_ins && cmd.instr_code == IN_SRESET &&
                       cmd.related_info == REL_OFF && wen_ff;

    // -----------------------------------------------------------
    // Command decode, gating and next state
    // -----------------------------------------------------------
    always_comb begin
        nxt_area = area_ff;
        nxt_wen  = wen_ff;
        nxt_fz   = fz_ff;
        nxt_prot = prot_ff;
        nxt_rsp  = rsp_ff;
        mem_we   = 1'b0;
        send     = cmd_valid;
        nxt_rsp.main_request_code = cmd.main_request_code;
        nxt_rsp.sub_request_code  = cmd.sub_request_code;
        nxt_rsp.resp_code = RC_OK;
        nxt_rsp.data      = 32'h0000_0000;
        if (is_rd) begin
            // Reads ignore area and write enable
            if (idx_ok) nxt_rsp.data = mem_ff[idx];
            else nxt_rsp.resp_code = RC_PARAM;
        end else if (is_wr) begin
            if (!idx_ok) nxt_rsp.resp_code = RC_PARAM;
            else if (!wen_ff) nxt_rsp.resp_code = RC_OPER;
            else if (cmd.var_type == VT_PROTECT &&
                     (area_ff != AREA_MEASURE || !prot_ff))
                nxt_rsp.resp_code = RC_OPER;
            else if (cmd.var_type == VT_SETUP &&
                     area_ff != AREA_SUSPEND)
                nxt_rsp.resp_code = RC_OPER;
            else mem_we = 1'b1; // Threshold any area
        end else if (is_ins) begin
            unique case (cmd.instr_code)
                IN_WEN: begin
                    if (cmd.related_info > REL_ON)
                        nxt_rsp.resp_code = RC_PARAM;
                    else nxt_wen = cmd.related_info[0];
                end
                IN_FZERO: begin
                    if (cmd.related_info > REL_ON)
                        nxt_rsp.resp_code = RC_PARAM;
                    else if (!wen_ff || area_ff != AREA_MEASURE)
                        nxt_rsp.resp_code = RC_OPER;
                    else if (fault || hold_ff)
                        nxt_rsp.resp_code = RC_OPER;
                    else nxt_fz = cmd.related_info[0];
                end
                IN_SRESET: begin
                    if (cmd.related_info != REL_OFF)
                        nxt_rsp.resp_code = RC_PARAM;
                    else if (!wen_ff) nxt_rsp.resp_code = RC_OPER;
                    else begin
                        nxt_area = AREA_MEASURE;
                        nxt_wen  = 1'b0;
                        nxt_fz   = 1'b0;
                        nxt_prot = 1'b0;
                        send     = 1'b0;
                    end
                end
                IN_AREA1: begin
                    if (cmd.related_info != REL_OFF)
                        nxt_rsp.resp_code = RC_PARAM;
                    else if (!wen_ff) nxt_rsp.resp_code = RC_OPER;
                    else if (area_ff == AREA_SUSPEND)
                        nxt_area = AREA_SUSPEND; // Ignored
                    else if (mem_ff[IDX_LOCK_INIT] == LOCK_NO_MOVE)
                        nxt_rsp.resp_code = RC_OPER;
                    else begin
                        nxt_area = AREA_SUSPEND;
                        nxt_prot = 1'b0;
                    end
                end
                IN_PROT: begin
                    if (cmd.related_info != REL_OFF)
                        nxt_rsp.resp_code = RC_PARAM;
                    else if (!wen_ff || area_ff != AREA_MEASURE)
                        nxt_rsp.resp_code = RC_OPER;
                    else nxt_prot = 1'b1;
                end
                default: nxt_rsp.resp_code = RC_PARAM;
            endcase
        end else if (cmd_valid) begin
            nxt_rsp.resp_code = RC_PARAM;
        end
        // Response holds between answers
        if (!send) nxt_rsp = rsp_ff;
        nxt_rv  = send;
        nxt_lrc = send ? nxt_rsp.resp_code : lrc_ff;
    end

    // Command state registers; area starts measuring
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            area_ff <= AREA_MEASURE;
            wen_ff  <= 1'b0;
            fz_ff   <= 1'b0;
            prot_ff <= 1'b0;
            rv_ff   <= 1'b0;
            rsp_ff  <= '0;
            lrc_ff  <= RC_OK;
        end else begin
            area_ff <= nxt_area;
            wen_ff  <= nxt_wen; // Also the adjustment view
            fz_ff   <= nxt_fz;
            prot_ff <= nxt_prot;
            rv_ff   <= nxt_rv;
            rsp_ff  <= nxt_rsp;
            lrc_ff  <= nxt_lrc;
        end
    end

    // Parameter store, kept across software reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) mem_ff[i] <= 32'h0000_0000;
        end else if (mem_we) begin
            mem_ff[idx] <= cmd.data;
        end
    end

    // -----------------------------------------------------------
    // Register port
    // -----------------------------------------------------------
    always_comb begin
        nxt_hold = hold_ff;
        nxt_rd   = 32'h0000_0000;
        if (reg_wr && reg_addr == REG_CTRL) nxt_hold = reg_wdata[CT_HOLD];
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    nxt_rd[ST_AREA]          = area_ff;
                    nxt_rd[ST_WEN]           = wen_ff;
                    nxt_rd[ST_FZ]            = fz_ff;
                    nxt_rd[ST_PROT]          = prot_ff;
                    nxt_rd[ST_FLT +: 3]      = flt_ff;
                end
                REG_CTRL:    nxt_rd[CT_HOLD] = hold_ff;
                REG_LAST_RC: nxt_rd[15:0]    = lrc_ff;
                default:     nxt_rd          = 32'h0000_0000;
            endcase
        end
    end

    // Register port flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_ff <= 1'b0;
            rd_ff   <= 32'h0000_0000;
        end else begin
            hold_ff <= nxt_hold;
            rd_ff   <= nxt_rd;
        end
    end

    assign rsp_valid    = rv_ff;
    assign rsp          = rsp_ff;
    assign reg_rdata    = rd_ff;
    assign measuring    = area_ff == AREA_MEASURE;
    assign write_enable = wen_ff;
    assign forced_zero  = fz_ff;

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_resp_follows: assert property (cmd_valid && !sreset_go |=>
        rsp_valid && rsp.main_request_code == $past(cmd.main_request_code))
        else $error("missing response");
    a_reset_silent: assert property (sreset_go |=>
        !rsp_valid && measuring && !write_enable && !forced_zero)
        else $error("software reset misbehaved");
    a_wen_follows: assert property (is_ins && cmd.instr_code == IN_WEN &&
        cmd.related_info <= REL_ON |=> write_enable == $past(cmd.related_info[0]))
        else $error("write enable not updated");
    a_locked_write: assert property (is_wr && idx_ok && !wen_ff |=>
        rsp.resp_code == RC_OPER)
        else $error("write accepted while disabled");
    a_setup_area0: assert property (is_wr && idx_ok && wen_ff &&
        cmd.var_type == VT_SETUP && measuring |=> rsp.resp_code == RC_OPER)
        else $error("setup write in area 0");
    a_prot_area1: assert property (is_wr && idx_ok && wen_ff &&
        cmd.var_type == VT_PROTECT && !measuring |=> rsp.resp_code == RC_OPER)
        else $error("protect write in area 1");
    a_fz_refused: assert property (is_ins && cmd.instr_code == IN_FZERO &&
        cmd.related_info <= REL_ON && (fault || hold_ff || !measuring)
        |=> rsp.resp_code == RC_OPER && $stable(forced_zero))
        else $error("forced zero not refused");
    a_area_move: assert property (is_ins && cmd.instr_code == IN_AREA1 &&
        cmd.related_info == REL_OFF && wen_ff && !measuring
        |=> !measuring && rsp.resp_code == RC_OK)
        else $error("area move not ignored");
    a_param_err: assert property (is_rd && !idx_ok |=>
        rsp.resp_code == RC_PARAM && rsp.data == 32'h0000_0000)
        else $error("bad address not refused");
    a_rsp_holds: assert property (
        !cmd_valid || sreset_go |=> $stable(rsp))
        else $error("response changed without an answer");
    a_fz_done: assert property (is_ins && cmd.instr_code == IN_FZERO &&
        cmd.related_info <= REL_ON && wen_ff && measuring &&
        !fault && !hold_ff |=> rsp.resp_code == RC_OK &&
        forced_zero == $past(cmd.related_info[0]))
        else $error("forced zero not applied");
    a_area_lock: assert property (is_ins && cmd.instr_code == IN_AREA1 &&
        cmd.related_info == REL_OFF && wen_ff && measuring &&
        mem_ff[IDX_LOCK_INIT] == LOCK_NO_MOVE
        |=> measuring && rsp.resp_code == RC_OPER)
        else $error("locked area move not refused");
    a_oper_write: assert property (is_wr && idx_ok && wen_ff &&
        cmd.var_type == VT_OPER |=> rsp.resp_code == RC_OK)
        else $error("threshold write refused");

    c_area_move: cover property (is_ins && cmd.instr_code == IN_AREA1
        ##1 !measuring);
    c_fz_done: cover property (is_ins && cmd.instr_code == IN_FZERO
        ##1 rsp_valid && rsp.resp_code == RC_OK);
    c_setup_write: cover property (!measuring && mem_we);
    c_soft_reset: cover property (sreset_go ##1 measuring);
endmodule
`default_nettype wire

// [tb/mph_host_model.sv]
// Host side of the command port: sends one or two decoded commands and
// catches the answers. Assumes a one-cycle answer slot after take.
`timescale 1ns/10ps
`default_nettype none
module mph_host_model (
    input  wire logic              clock,
    input  wire logic              rsp_valid,
    input  wire mph_pkg::mph_rsp_t rsp,
    output var  logic              cmd_valid,
    output var  mph_pkg::mph_cmd_t cmd
);
    import mph_pkg::*;

    // Idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // One single-element command, answer looked at in its slot
    task automatic exec(input mph_cmd_t c, output logic got,
                        output mph_rsp_t r);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd       <= c;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd       <= ~c; // Released fields show no stale value
        #1;
        got = rsp_valid;
        r   = rsp;
    endtask

    // Two commands on consecutive edges
    task automatic exec2(input mph_cmd_t c1, input mph_cmd_t c2,
                         output mph_rsp_t r1, output mph_rsp_t r2);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd       <= c1;
        @(posedge clock);
        cmd       <= c2;
        #1;
        r1 = rsp;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd       <= ~c2;
        #1;
        r2 = rsp;
    endtask
endmodule
`default_nettype wire

// [tb/meter_param_command_handler_test.sv]
// Self-checking bench of the parameter command handler.
// Assumes the host model drives the command port.
`timescale 1ns/10ps
`default_nettype none
module meter_param_command_handler_test;
    import mph_pkg::*;

    typedef struct {
        mph_cmd_t    c;
        logic [15:0] rc;
        logic [31:0] rd;
    } mph_row_t;

    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        cmd_valid;
    mph_cmd_t    cmd;
    logic        rsp_valid;
    mph_rsp_t    rsp;
    logic [2:0]  flt = 3'h0;
    logic        measuring;
    logic        write_enable;
    logic        forced_zero;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    int          miscompares = 0;
    int          n_checks = 0;
    mph_row_t    rows[$];
    mph_rsp_t    r1;
    mph_rsp_t    r2;
    logic [31:0] d;

    // 10 MHz clock
    always #50 clock = ~clock;

    mph_command_handler u_dut (
        .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
        .no_value_pin(flt[0]), .anomaly_pin(flt[1]),
        .range_over_pin(flt[2]), .measuring(measuring),
        .write_enable(write_enable), .forced_zero(forced_zero),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    mph_host_model u_host (
        .clock(clock), .rsp_valid(rsp_valid), .rsp(rsp),
        .cmd_valid(cmd_valid), .cmd(cmd));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic mph_row_t mk(logic [7:0] sc, logic [7:0] k,
        logic [15:0] a, logic [7:0] rel, logic [31:0] dv,
        logic [15:0] rc);
        mph_row_t w;
        if (sc == SC_INSTR)
            w.c = '{MC_OPER, sc, 8'h00, 16'h0000, k, rel, 32'h0};
        else
            w.c = '{MC_VAR, sc, k, a, 8'h00, 8'h00, dv};
        w.rc = rc;
        w.rd = dv;
        return w;
    endfunction

    // Send one command and compare its answer
    task automatic run(input mph_row_t w);
        logic     got;
        mph_rsp_t r;
        u_host.exec(w.c, got, r);
        check("answered", 32'(got), 32'h1);
        check("code", 32'(r.resp_code), 32'(w.rc));
        check("echo", 32'({r.main_request_code, r.sub_request_code}),
              32'({w.c.main_request_code, w.c.sub_request_code}));
        if (w.c.sub_request_code == SC_READ && w.rc == RC_OK)
            check("data", r.data, w.rd);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Watchdog well past the expected run of under two hundred cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        print_verdict();
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h1, 0, 32'h11, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_WEN, 0, 8'h02, 0, RC_PARAM));
        rows.push_back(mk(SC_INSTR, IN_WEN, 0, REL_ON, 0, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h1, 0, 32'h11, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h6, 0, 32'h66, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h7, 0, 32'h5, RC_PARAM));
        rows.push_back(mk(SC_READ, VT_OPER, 16'h1, 0, 32'h11, RC_OK));
        rows.push_back(mk(SC_READ, VT_OPER, 16'h6, 0, 32'h66, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_SETUP, 16'h0, 0, 32'h1, RC_OPER));
        rows.push_back(mk(SC_READ, VT_SETUP, 16'h1D, 0, 32'h0, RC_OK));
        rows.push_back(mk(SC_READ, VT_SETUP, 16'h1E, 0, 32'h0, RC_PARAM));
        rows.push_back(mk(SC_READ, 8'hC4, 16'h0, 0, 32'h0, RC_PARAM));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h0, 0, 32'h1, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_PROT, 0, REL_OFF, 0, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h2, 0, 32'h1, RC_OK));
        rows.push_back(mk(SC_READ, VT_PROTECT, 16'h2, 0, 32'h1, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h4, 0, 32'h1, RC_PARAM));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h1, 0, 32'h2, RC_OK));
        rows.push_back(mk(SC_INSTR, IN_AREA1, 0, REL_OFF, 0, RC_OPER));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h1, 0, 32'h0, RC_OK));
        rows.push_back(mk(SC_INSTR, IN_FZERO, 0, REL_ON, 0, RC_OK));
        rows.push_back(mk(SC_INSTR, IN_FZERO, 0, REL_OFF, 0, RC_OK));
        rows.push_back(mk(SC_INSTR, IN_FZERO, 0, 8'h02, 0, RC_PARAM));
        rows.push_back(mk(SC_INSTR, IN_AREA1, 0, REL_OFF, 0, RC_OK));
        rows.push_back(mk(SC_INSTR, IN_AREA1, 0, REL_OFF, 0, RC_OK));
        rows.push_back(mk(SC_READ, VT_OPER, 16'h1, 0, 32'h11, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h2, 0, 32'h22, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_SETUP, 16'h1D, 0, 32'h7, RC_OK));
        rows.push_back(mk(SC_READ, VT_SETUP, 16'h1D, 0, 32'h7, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_PROTECT, 16'h0, 0, 32'h1, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_FZERO, 0, REL_ON, 0, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_WEN, 0, REL_OFF, 0, RC_OK));
        rows.push_back(mk(SC_WRITE, VT_OPER, 16'h3, 0, 32'h5, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_SRESET, 0, REL_OFF, 0, RC_OPER));
        rows.push_back(mk(SC_INSTR, IN_WEN, 0, REL_ON, 0, RC_OK));
        repeat (2) @(posedge clock);
        check("measuring", 32'(measuring), 32'h1);
        check("wen", 32'(write_enable), 32'h0);
        repeat (14) @(posedge clock);
        reset_n <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        // Software reset: silent, mode flags back to power-on values, parameter store kept
        u_host.exec(mk(SC_INSTR, IN_SRESET, 0, REL_OFF, 0, 0).c, d[0], r1);
        check("silent", 32'(d[0]), 32'h0);
        check("measuring", 32'(measuring), 32'h1);
        check("wen", 32'(write_enable), 32'h0);
        reg_read(REG_STATUS, d);
        check("status", d, 32'h0);
        run(mk(SC_READ, VT_SETUP, 16'h1D, 0, 32'h7, RC_OK));
        run(mk(SC_INSTR, IN_WEN, 0, REL_ON, 0, RC_OK));
        check("wen", 32'(write_enable), 32'h1);
        // Value hold refuses forced zero
        reg_write(REG_CTRL, 32'h1);
        reg_read(REG_CTRL, d);
        check("ctrl", d, 32'h1);
        run(mk(SC_INSTR, IN_FZERO, 0, REL_ON, 0, RC_OPER));
        reg_read(REG_LAST_RC, d);
        check("last code", d, 32'(RC_OPER));
        check("rsp stands", 32'(rsp.resp_code), 32'(RC_OPER));
        reg_write(REG_CTRL, 32'h0);
        // Each measurement fault refuses forced zero
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            flt <= 3'(1 << k);
            repeat (4) @(posedge clock);
            run(mk(SC_INSTR, IN_FZERO, 0, REL_ON, 0, RC_OPER));
            @(posedge clock);
            flt <= 3'h0;
            repeat (4) @(posedge clock);
        end
        run(mk(SC_INSTR, IN_FZERO, 0, REL_ON, 0, RC_OK));
        check("fz on", 32'(forced_zero), 32'h1);
        reg_read(REG_STATUS, d);
        check("status", d, 32'h6);
        run(mk(SC_INSTR, IN_FZERO, 0, REL_OFF, 0, RC_OK));
        check("fz off", 32'(forced_zero), 32'h0);
        reg_read(8'hFC, d);
        check("unmapped", d, 32'h0);
        // Write then read on consecutive edges
        u_host.exec2(mk(SC_WRITE, VT_OPER, 16'h4, 0, 32'h44, 0).c,
                     mk(SC_READ, VT_OPER, 16'h4, 0, 0, 0).c, r1, r2);
        check("b2b write", 32'(r1.resp_code), 32'(RC_OK));
        check("b2b read", r2.data, 32'h44);
        // Mid-run reset: power-on state, parameter store cleared
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        check("rst valid", 32'(rsp_valid), 32'h0);
        check("rst measuring", 32'(measuring), 32'h1);
        check("rst wen", 32'(write_enable), 32'h0);
        reset_n <= 1'b1;
        run(mk(SC_READ, VT_OPER, 16'h4, 0, 32'h0, RC_OK));
        print_verdict();
    end
endmodule
`default_nettype wire
